// ==== pkg/oalsr_defines.svh ====
// constants of the octal converter readout: sizes, channel start points and timing counts
// assumes a core clock of 25 MHz and a serial clock that the host makes
`ifndef OALSR_DEFINES_SVH
`define OALSR_DEFINES_SVH

`define OALSR_CHANNELS 8
`define OALSR_BITS 16
`define OALSR_FRAME_BITS 128
`define OALSR_LANES 4
// bits between the first channels of neighbouring lanes (two channels per lane)
`define OALSR_LANE_STRIDE 7'h20
// core clock and throughput
`define OALSR_CLK_HZ 25000000
`define OALSR_CLK_NS 40
// shortest conversion cycle per channel, 1.5 Msps
`define OALSR_CYCLE_NS 667
`define OALSR_CYCLE_CLKS ((`OALSR_CYCLE_NS) / (`OALSR_CLK_NS))
// serial clock cycles per lane to read both channels
`define OALSR_SDR_EDGES 32
`define OALSR_DDR_EDGES 16
// first trial bit of the successive approximation
`define OALSR_SAR_TOP 4'hF
`define OALSR_SAR_RESET 16'h0000

`endif

// ==== pkg/oalsr_pkg.sv ====
// types of the octal converter readout
// assumes oalsr_defines.svh for the sizes
`include "oalsr_defines.svh"

package oalsr_pkg;

  typedef enum logic [1:0]
  {
    OALSR_ACQUIRE,
    OALSR_CONVERT,
    OALSR_HOLD
  } oalsr_state_e;

  typedef logic [`OALSR_BITS-1:0] oalsr_word_t;
  typedef logic [`OALSR_CHANNELS-1:0][`OALSR_BITS-1:0] oalsr_octal_t;
  typedef logic [`OALSR_FRAME_BITS-1:0] oalsr_frame_t;
  typedef logic [6:0] oalsr_pos_t;

endpackage

// ==== sim/oalsr_host_model.sv ====
// host reader of the four data pairs
// assumes it owns the serial clock, which rests low between frames
module oalsr_host_model
  import oalsr_pkg::*;
(
  output logic serial_clock_out,
  input wire logic echo_p_in,
  input wire logic echo_n_in,
  input wire logic [3:0] lane_p_in,
  input wire logic [3:0] lane_n_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial serial_clock_out = 1'b0;
  task automatic read_frame(input logic ddr, output oalsr_frame_t cap [4], output int bad);
    bad = 0;
    for (int k = 0; k < 128; k++)
    begin
      for (int j = 0; j < 4; j++)
      begin
        cap[j][127-k] = lane_p_in[j];
        if (lane_n_in[j] === lane_p_in[j])
          bad++;
      end
      if (echo_p_in !== serial_clock_out || echo_n_in === echo_p_in)
        bad++;
      #3;
      if (!ddr)
      begin
        serial_clock_out = 1'b1;
        #6;
      end
      serial_clock_out = ~serial_clock_out;
      #3;
    end
  endtask
endmodule

// ==== sim/oalsr_readout_chk.sv ====
// checker of the readout control and pin pairs
// assumes it is bound to oalsr_readout
module oalsr_readout_chk (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic serial_clock_in,
  input wire logic convert_strobe_n_in,
  input wire logic io_select_in,
  input wire logic io_select_float_in,
  input wire logic busy_out,
  input wire logic sample_hold_out,
  input wire logic differential_mode_out,
  input wire logic lanes_enable_out,
  input wire logic echo_clock_p_out,
  input wire logic echo_clock_n_out,
  input wire logic lane_one_pair_p_out,
  input wire logic lane_one_pair_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  strobe_start_a:
    assert property ($fell(convert_strobe_n_in) && sample_hold_out |-> ##[2:6] busy_out)
    else $error("no conversion after strobe");
  convert_len_a:
    assert property ($rose(busy_out) |-> busy_out[*8] ##[8:12] !busy_out)
    else $error("conversion length wrong");
  hold_busy_a:
    assert property (busy_out |-> !sample_hold_out)
    else $error("acquiring while busy");
  diff_on_a:
    assert property (io_select_in[*4] |-> differential_mode_out)
    else $error("differential mode missing");
  diff_off_a:
    assert property ((!io_select_in && !io_select_float_in)[*5] |-> !differential_mode_out)
    else $error("differential mode stuck");
  lanes_on_a:
    assert property (differential_mode_out[*3] |-> lanes_enable_out)
    else $error("lanes not enabled");
  echo_follow_a:
    assert property (echo_clock_p_out == (serial_clock_in && lanes_enable_out))
    else $error("echo clock mismatch");
  echo_pair_a:
    assert property (lanes_enable_out |-> echo_clock_n_out == !echo_clock_p_out)
    else $error("echo pair not inverse");
  lane_pair_a:
    assert property (lanes_enable_out |-> lane_one_pair_n_out != lane_one_pair_p_out)
    else $error("lane pair not inverse");
endmodule

bind oalsr_readout oalsr_readout_chk u_chk (
  .ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in),
  .serial_clock_in(serial_clock_in),
  .convert_strobe_n_in(convert_strobe_n_in),
  .io_select_in(io_select_in),
  .io_select_float_in(io_select_float_in),
  .busy_out(busy_out),
  .sample_hold_out(sample_hold_out),
  .differential_mode_out(differential_mode_out),
  .lanes_enable_out(lanes_enable_out),
  .echo_clock_p_out(echo_clock_p_out),
  .echo_clock_n_out(echo_clock_n_out),
  .lane_one_pair_p_out(lane_one_pair_p_out),
  .lane_one_pair_n_out(lane_one_pair_n_out)
);

// ==== sim/oalsr_readout_tb_top.sv ====
// top bench of the octal converter readout
// assumes the design, its bound checker and the host reader model
`include "oalsr_defines.svh"
module oalsr_readout_tb_top
  import oalsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, stb_n, rate, io_sel, io_flt, sck, busy, hold, diff, lowp, en, ep, epn;
  logic [3:0] lp, ln;
  logic [7:0] comp;
  oalsr_octal_t dac;
  oalsr_word_t ta [8], tb [8], tc [8], tgt [8];
  int fails, cmp_count, cyc;
  // comparator of each channel against its target code
  for (genvar i = 0; i < 8; i++)
  begin
    assign comp[i] = dac[i] <= tgt[i];
  end
  oalsr_readout u_dut (
    .ref_clk_in(clk),
    .rst_n_in(rst_n),
    .serial_clock_in(sck),
    .convert_strobe_n_in(stb_n),
    .rate_select_in(rate),
    .io_select_in(io_sel),
    .io_select_float_in(io_flt),
    .comparator_in(comp),
    .sample_hold_out(hold),
    .busy_out(busy),
    .differential_mode_out(diff),
    .low_power_link_out(lowp),
    .capacitive_dac_out(dac),
    .lane_one_pair_p_out(lp[0]),
    .lane_one_pair_n_out(ln[0]),
    .lane_two_pair_p_out(lp[1]),
    .lane_two_pair_n_out(ln[1]),
    .lane_three_pair_p_out(lp[2]),
    .lane_three_pair_n_out(ln[2]),
    .lane_four_pair_p_out(lp[3]),
    .lane_four_pair_n_out(ln[3]),
    .echo_clock_p_out(ep),
    .echo_clock_n_out(epn),
    .lanes_enable_out(en)
  );
  oalsr_host_model u_host (
    .serial_clock_out(sck),
    .echo_p_in(ep),
    .echo_n_in(epn),
    .lane_p_in(lp),
    .lane_n_in(ln)
  );
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic oalsr_frame_t mk(input oalsr_word_t t [8]);
    oalsr_frame_t f;
    for (int i = 0; i < 8; i++)
      f[127-16*i -: 16] = t[i] ^ 16'h8000;
    return f;
  endfunction
  task automatic convert(input oalsr_word_t t [8]);
    int n;
    tgt = t;
    @(negedge clk) stb_n = 1'b0;
    for (n = 0; n < 10 && busy !== 1'b1; n++)
      @(negedge clk);
    chk({127'h0, busy}, 128'h1);
    for (n = 0; n < 30 && busy !== 1'b0; n++)
      @(negedge clk);
    chk({127'h0, busy}, 128'h0);
    stb_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic read_check(input logic ddr, input oalsr_frame_t f);
    oalsr_frame_t cap [4];
    int bad;
    u_host.read_frame(ddr, cap, bad);
    chk(128'(bad), 128'h0);
    for (int j = 0; j < 4; j++)
      chk(cap[j], (f << (32 * j)) | (f >> (128 - 32 * j)));
    chk(128'(clamp_half(cap[0][111:96])), 128'(clamp_half(f[111:96])));
  endtask
  function automatic oalsr_word_t clamp_half(input oalsr_word_t c);
    if ($signed(c) > $signed(16'h3FFF))
      return 16'h3FFF;
    else if ($signed(c) < $signed(16'hC000))
      return 16'hC000;
    return c;
  endfunction
  task automatic t_reset();
    {rst_n, stb_n, rate, io_sel, io_flt} = 5'b01010;
    repeat (12) @(negedge clk);
    chk({124'h0, hold, busy, en, ep}, 128'h8);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk({124'h0, hold, busy, en, ep}, 128'hA);
    $display("test reset done");
  endtask
  task automatic t_sdr();
    @(negedge clk) rate = 1'b0;
    convert(ta);
    convert(tb);
    read_check(1'b0, mk(ta));
    $display("test sdr done");
  endtask
  task automatic t_ddr();
    @(negedge clk) rate = 1'b1;
    convert(tc);
    read_check(1'b1, mk(tb));
    $display("test ddr done");
  endtask
  task automatic t_mode();
    @(negedge clk) io_sel = 1'b0;
    repeat (8) @(negedge clk);
    chk({124'h0, diff, en, lp[0], ep}, 128'h0);
    io_flt = 1'b1;
    repeat (8) @(negedge clk);
    chk({125'h0, diff, lowp, en}, 128'h7);
    io_sel = 1'b1;
    io_flt = 1'b0;
    repeat (8) @(negedge clk);
    chk({126'h0, diff, lowp}, 128'h2);
    $display("test mode done");
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    ta = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF, 16'h0001, 16'hFFFE, 16'h1234, 16'hABCD};
    foreach (ta[i])
    begin
      tb[i] = ta[i] ^ 16'h5A5A;
      tc[i] = ~ta[i];
    end
    tgt = ta;
    t_reset();
    t_sdr();
    t_ddr();
    t_mode();
    summarize();
  end
endmodule

// ==== verilog/oalsr_readout.sv ====
// conversion sequencing and differential serial readout of an eight channel converter
// assumes the host drives the convert strobe and the serial clock; the comparator and
// trial dac of each channel sit outside and are clocked by the core clock
//
// Behaviour
// - high or floating select picks differential output
// - single rate shifts MSB first on falling edges
// - double rate shifts on both serial edges
// - lane one carries ch1, ch2, then ch3 onward
// - lane two carries ch3, ch4, then onward wrapping
// - lane three carries ch5, ch6, then onward wrapping
// - lane four carries ch7, ch8, then ch1 onward
// - echo clock mirrors serial clock for capture
// - strobe falling edge starts conversion on all
// - sixteen step successive approximation per channel
// - finished codes prepared for serial transfer
// - results in two's complement format
// - results delivered one conversion cycle later
// - rate strap low single, high double rate
`include "oalsr_defines.svh"
module oalsr_readout
  import oalsr_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic serial_clock_in,
  input wire logic convert_strobe_n_in,
  input wire logic rate_select_in,
  input wire logic io_select_in,
  input wire logic io_select_float_in,
  input wire logic [`OALSR_CHANNELS-1:0] comparator_in,
  output logic sample_hold_out,
  output logic busy_out,
  output logic differential_mode_out,
  output logic low_power_link_out,
  output oalsr_octal_t capacitive_dac_out,
  output logic lane_one_pair_p_out,
  output logic lane_one_pair_n_out,
  output logic lane_two_pair_p_out,
  output logic lane_two_pair_n_out,
  output logic lane_three_pair_p_out,
  output logic lane_three_pair_n_out,
  output logic lane_four_pair_p_out,
  output logic lane_four_pair_n_out,
  output logic echo_clock_p_out,
  output logic echo_clock_n_out,
  output logic lanes_enable_out
);

  // bit of the frame that a lane shows at a given serial position
  function automatic logic frame_bit(input oalsr_frame_t frame, input oalsr_pos_t start,
                                     input oalsr_pos_t pos);
    oalsr_pos_t idx;
    idx = start + pos;
    frame_bit = frame[7'h7F - idx];
  endfunction

  // offset binary trial result turned into two's complement
  function automatic oalsr_word_t to_twos(input oalsr_word_t sar);
    to_twos = {~sar[`OALSR_BITS-1], sar[`OALSR_BITS-2:0]};
  endfunction

  // ---------------- core domain ----------------

  logic strobe_meta_r;
  logic strobe_sync_r;
  logic strobe_prev_r;
  logic rate_meta_r;
  logic rate_sync_r;
  logic sel_meta_r;
  logic sel_sync_r;
  logic flt_meta_r;
  logic flt_sync_r;
  logic strobe_fall;

  // two stage synchronisers for the pins
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      strobe_meta_r <= 1'b1;
      strobe_sync_r <= 1'b1;
      rate_meta_r <= 1'b0;
      rate_sync_r <= 1'b0;
      sel_meta_r <= 1'b1;
      sel_sync_r <= 1'b1;
      flt_meta_r <= 1'b0;
      flt_sync_r <= 1'b0;
    end
    else
    begin
      strobe_meta_r <= convert_strobe_n_in;
      strobe_sync_r <= strobe_meta_r;
      rate_meta_r <= rate_select_in;
      rate_sync_r <= rate_meta_r;
      sel_meta_r <= io_select_in;
      sel_sync_r <= sel_meta_r;
      flt_meta_r <= io_select_float_in;
      flt_sync_r <= flt_meta_r;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      strobe_prev_r <= 1'b1;
    end
    else
    begin
      strobe_prev_r <= strobe_sync_r;
    end
  end

  assign strobe_fall = strobe_prev_r & ~strobe_sync_r;

  // io mode from the select pin, high or floating
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      differential_mode_out <= 1'b1;
      low_power_link_out <= 1'b0;
      lanes_enable_out <= 1'b0;
    end
    else
    begin
      differential_mode_out <= sel_sync_r | flt_sync_r;
      low_power_link_out <= flt_sync_r;
      lanes_enable_out <= sel_sync_r | flt_sync_r;
    end
  end

  oalsr_state_e state_r;
  logic [3:0] bit_r;
  oalsr_octal_t sar_r;
  oalsr_octal_t done_r;
  oalsr_frame_t readout_r;
  logic rate_r;
  logic link_clear_r;

  // conversion sequence; a strobe edge during conversion is ignored
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= OALSR_ACQUIRE;
      bit_r <= `OALSR_SAR_TOP;
    end
    else
    begin
      case (state_r)
        OALSR_ACQUIRE:
        begin
          if (strobe_fall)
          begin
            state_r <= OALSR_CONVERT;
            bit_r <= `OALSR_SAR_TOP;
          end
        end
        OALSR_CONVERT:
        begin
          if (bit_r == 4'h0)
          begin
            state_r <= OALSR_HOLD;
          end
          else
          begin
            bit_r <= bit_r - 4'h1;
          end
        end
        OALSR_HOLD:
        begin
          state_r <= OALSR_ACQUIRE;
        end
        default:
        begin
          state_r <= OALSR_ACQUIRE;
        end
      endcase
    end
  end

  // one trial bit per clock for every channel at once
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sar_r <= '0;
    end
    else if (state_r == OALSR_ACQUIRE && strobe_fall)
    begin
      sar_r <= '0;
    end
    else if (state_r == OALSR_CONVERT)
    begin
      for (int ch = 0; ch < `OALSR_CHANNELS; ch++)
      begin
        sar_r[ch][bit_r] <= comparator_in[ch];
      end
    end
  end

  // trial code offered to each channel's dac: kept bits plus the bit under test
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      capacitive_dac_out <= '0;
    end
    else
    begin
      for (int ch = 0; ch < `OALSR_CHANNELS; ch++)
      begin
        if (state_r == OALSR_ACQUIRE && strobe_fall)
        begin
          capacitive_dac_out[ch] <= 16'h8000;
        end
        else if (state_r == OALSR_CONVERT && bit_r != 4'h0)
        begin
          capacitive_dac_out[ch] <= (sar_r[ch] | (16'h0001 << bit_r)
                                     | (comparator_in[ch] ? (16'h0001 << bit_r) : 16'h0000))
                                    & ~(16'h0001 << bit_r) | (16'h0001 << (bit_r - 4'h1))
                                    | (comparator_in[ch] ? (16'h0001 << bit_r) : 16'h0000);
        end
        else if (state_r != OALSR_CONVERT)
        begin
          capacitive_dac_out[ch] <= `OALSR_SAR_RESET;
        end
      end
    end
  end

  // finished codes kept in two's complement for transfer
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      done_r <= '0;
    end
    else if (state_r == OALSR_HOLD)
    begin
      for (int ch = 0; ch < `OALSR_CHANNELS; ch++)
      begin
        done_r[ch] <= to_twos(sar_r[ch]);
      end
    end
  end

  // previous results go out while the new sample converts
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      readout_r <= '0;
      rate_r <= 1'b0;
    end
    else if (state_r == OALSR_ACQUIRE && strobe_fall)
    begin
      for (int ch = 0; ch < `OALSR_CHANNELS; ch++)
      begin
        readout_r[`OALSR_FRAME_BITS-1-ch*`OALSR_BITS -: `OALSR_BITS] <= done_r[ch];
      end
      // rate strap taken once per frame
      rate_r <= rate_sync_r;
    end
  end

  // one pulse that rewinds the serial position for a new frame
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      link_clear_r <= 1'b1;
    end
    else
    begin
      link_clear_r <= (state_r == OALSR_ACQUIRE) & strobe_fall;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sample_hold_out <= 1'b1;
      busy_out <= 1'b0;
    end
    else
    begin
      sample_hold_out <= (state_r == OALSR_ACQUIRE) & ~strobe_fall;
      busy_out <= (state_r != OALSR_ACQUIRE) | strobe_fall;
    end
  end

  // ---------------- link domain ----------------
  // readout_r and rate_r stay still for the whole frame; the clear pulse is the
  // handshake that marks them new, so the serial side reads them without a sync

  logic link_rst_n;
  oalsr_pos_t fall_cnt_r;
  oalsr_pos_t rise_cnt_r;
  oalsr_pos_t pos;

  assign link_rst_n = rst_n_in & ~link_clear_r;

  // falling edges advance the position in both rates
  always_ff @(negedge serial_clock_in or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      fall_cnt_r <= '0;
    end
    else
    begin
      fall_cnt_r <= fall_cnt_r + 7'h01;
    end
  end

  // rising edges advance it as well in double rate
  always_ff @(posedge serial_clock_in or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      rise_cnt_r <= '0;
    end
    else if (rate_r)
    begin
      rise_cnt_r <= rise_cnt_r + 7'h01;
    end
  end

  // the position wraps after all eight channels
  assign pos = fall_cnt_r + rise_cnt_r;

  // each lane starts two channels after the previous one
  always_comb
  begin
    lane_one_pair_p_out = lanes_enable_out & frame_bit(readout_r, 7'h00, pos);
    lane_two_pair_p_out = lanes_enable_out & frame_bit(readout_r, `OALSR_LANE_STRIDE, pos);
    lane_three_pair_p_out = lanes_enable_out
                            & frame_bit(readout_r, 7'(2 * `OALSR_LANE_STRIDE), pos);
    lane_four_pair_p_out = lanes_enable_out
                           & frame_bit(readout_r, 7'(3 * `OALSR_LANE_STRIDE), pos);
    lane_one_pair_n_out = lanes_enable_out & ~lane_one_pair_p_out;
    lane_two_pair_n_out = lanes_enable_out & ~lane_two_pair_p_out;
    lane_three_pair_n_out = lanes_enable_out & ~lane_three_pair_p_out;
    lane_four_pair_n_out = lanes_enable_out & ~lane_four_pair_p_out;
  end

  // echo clock follows the serial clock through the same output path
  always_comb
  begin
    echo_clock_p_out = lanes_enable_out & serial_clock_in;
    echo_clock_n_out = lanes_enable_out & ~serial_clock_in;
  end

endmodule
